// *** verilog/pfcn_pkg.sv ***
// shared constants for the fault-clear / write-lock / nonvolatile command block
// assumes both link ends import it whole
package pfcn_pkg;
  // ************************************************************
  // command codes
  // ************************************************************
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ON_OFF = 8'h02;
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_WLOCK = 8'h10;
  localparam logic [7:0] CMD_STORE = 8'h11;
  localparam logic [7:0] CMD_RESTORE = 8'h12;
  localparam logic [7:0] CMD_VOUT = 8'h21;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_COMM = 8'h7e;
  localparam logic [7:0] CMD_VENDOR_F0 = 8'hf0;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int LOCK_ALLOW_CORE_CMDS = 5;
  localparam int LOCK_ALLOW_OPERATION = 6;
  localparam int LOCK_ALLOW_PROTECT_ONLY = 7;
  localparam int OVERVOLT_RELEASE_SELECT = 0;
  localparam int STB_OTHER = 0;
  localparam int STB_COMM = 1;
  localparam int STB_OVERVOLT = 5;
  localparam int STC_BAD_CMD = 7;
  localparam int STC_BAD_DATA = 6;
  localparam int STC_MEMORY = 4;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] WLOCK_RST = 8'h00;
  localparam logic [7:0] OPERATION_RST = 8'h00;
  localparam logic [7:0] ON_OFF_RST = 8'h16;
  localparam logic [15:0] VOUT_RST = 16'h0000;
  localparam logic [7:0] VENDOR_F0_RST = 8'h00;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_HALF_CYC = 3;
  localparam int LINK_PERIOD_NS = 2 * LINK_HALF_CYC * CLK_PERIOD_NS; // device counts link cycles
  localparam int ENPIN_LOW_NS = 100;
  // rounded down: any low pulse past the limit is sampled at least this often
  localparam int ENPIN_LOW_CYC = ENPIN_LOW_NS / LINK_PERIOD_NS;
  localparam int NVM_BUSY_MS = 100;
  localparam int NVM_BUSY_CYC = NVM_BUSY_MS * 1000000 / LINK_PERIOD_NS;
  localparam int NVM_SLOTS = 5;
endpackage

// *** verilog/pfcn_link_if.sv ***
// link between the converter command block and its bus host
// assumes the host end makes link_clk and only changes cmd_valid as link_clk falls
`timescale 1ns/1ps
`default_nettype none
interface pfcn_link_if;
  logic link_clk; // clock made by the host
  logic cmd_valid; // request held until rsp_valid seen
  logic cmd_write; // 1 write, 0 read
  logic [7:0] cmd_code; // command code
  logic [15:0] cmd_data; // write data
  logic rsp_valid; // answer held until cmd_valid drops
  logic rsp_nack; // answer refused
  logic [15:0] rsp_data; // read data
  logic alert; // alert level, high while asserted
  modport dev (input link_clk, cmd_valid, cmd_write, cmd_code, cmd_data,
    output rsp_valid, rsp_nack, rsp_data, alert);
  modport host (output link_clk, cmd_valid, cmd_write, cmd_code, cmd_data,
    input rsp_valid, rsp_nack, rsp_data, alert);
endinterface
`default_nettype wire

// *** verilog/pfcn_dev_end.sv ***
// converter side: fault clearing, write locking and nonvolatile store/restore
// assumes link_clk from the host end; reset synchronous to link_clk
// Operation
// - clear-faults zeroes every status bit together
// - clear-faults releases alert with the bits
// - clear-faults never restarts a latched-off converter
// - still-present fault sets its flag again
// - host waits ramp and delay before clearing
// - overvolt latch holds low-side; optional feedback release
// - without release select, clear-faults frees low-side
// - long-low enable pin toggle also clears faults
// - reads of supported codes always succeed whatever the lock
// - restore leaves locked registers untouched
// - top lock level allows only lock writes; clear, store and restore writes still pass
// - middle level also allows operation
// - core level adds on-off config, vout
// - several lock bits raise comm fault, alert
// - invalid lock value applies no lock
// - store copies storable settings to nonvolatile
// - store keeps switching, ignores faults meanwhile
// - store/restore busy about 100 ms, silent
// - program failure nacks, sets comm and memory
// - restore reloads only unlocked registers
// - host stops converter before restore
// - user store/restore alias default ones; only the default store and restore codes are decoded
`timescale 1ns/1ps
`default_nettype none
module pfcn_dev_end
  import pfcn_pkg::*;
#(
  parameter int BUSY_CYC = NVM_BUSY_CYC // nonvolatile busy span, shortened in simulation
) (
  input wire logic reset,
  pfcn_link_if.dev link,
  input wire logic enable_pin_input,
  input wire logic overvolt_fault_in,
  input wire logic other_fault_in,
  input wire logic feedback_below_in,
  input wire logic nvm_fail_in,
  output logic low_side_switch_on,
  output logic latched_off,
  output logic faults_ignored,
  output logic switching_halted,
  output logic [7:0] operation_out,
  output logic [7:0] on_off_out,
  output logic [15:0] vout_out
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [4:0] sy1; // first sync stage, read only by sy2
    logic [4:0] sy2; // {enable, feedback, overvolt, other, nvm_fail}
    logic en_prev; // enable pin one cycle back
    logic [3:0] en_low_cnt; // saturating low-time counter
    logic rsp_valid;
    logic rsp_nack;
    logic [15:0] rsp_data;
    logic alert;
    logic [7:0] wlock; // write_lock_level
    logic [7:0] oper;
    logic [7:0] on_off;
    logic [15:0] vout;
    logic [7:0] vendor; // vendor_config_f0
    logic [7:0] st_byte; // summary status
    logic [7:0] st_comm; // communication status
    logic ls_on; // low-side switch held on
    logic latched; // converter latched off
    logic busy; // nonvolatile operation running
    logic busy_store; // 1 store, 0 restore
    logic [23:0] busy_cnt;
    logic [NVM_SLOTS-1:0][15:0] nvm; // nonvolatile image
  } pfcn_dev_type;
  pfcn_dev_type s_r, s_nxt;
  localparam logic [23:0] BUSY_LAST = 24'(BUSY_CYC - 1); // last count of the busy span
  localparam logic [3:0] EN_LOW_MIN = 4'(ENPIN_LOW_CYC); // shortest low counted as toggle
  // ************************************************************
  // lock decoding
  // ************************************************************
  // true when no more than one lock bit is set
  function automatic logic lock_valid(input logic [7:0] lvl);
    return $countones({lvl[LOCK_ALLOW_PROTECT_ONLY], lvl[LOCK_ALLOW_OPERATION],
                       lvl[LOCK_ALLOW_CORE_CMDS]}) < 2;
  endfunction
  // true when a write to code passes the lock level
  function automatic logic lock_allows(input logic [7:0] lvl, input logic [7:0] code);
    logic ok;
    ok = 1'b1;
    if (!lock_valid(lvl)) begin
      ok = 1'b1;
    end else if (lvl[LOCK_ALLOW_PROTECT_ONLY]) begin
      ok = (code == CMD_WLOCK);
    end else if (lvl[LOCK_ALLOW_OPERATION]) begin
      ok = (code == CMD_WLOCK) || (code == CMD_OPERATION);
    end else if (lvl[LOCK_ALLOW_CORE_CMDS]) begin
      ok = (code == CMD_WLOCK) || (code == CMD_OPERATION) || (code == CMD_ON_OFF) ||
           (code == CMD_VOUT);
    end
    return ok;
  endfunction
  // ************************************************************
  // next state
  // ************************************************************
  // one pass: sync, clear, command, busy, then fault sets so a set wins
  always_comb begin
    logic ov, oth, fb_low, en, clr, take;
    s_nxt = s_r;
    s_nxt.sy1 = {enable_pin_input, feedback_below_in, overvolt_fault_in, other_fault_in,
                 nvm_fail_in};
    s_nxt.sy2 = s_r.sy1;
    en = s_r.sy2[4];
    fb_low = s_r.sy2[3];
    ov = s_r.sy2[2] && !(s_r.busy && s_r.busy_store);
    oth = s_r.sy2[1] && !(s_r.busy && s_r.busy_store);
    take = link.cmd_valid && !s_r.rsp_valid && !s_r.busy;
    clr = take && link.cmd_write && (link.cmd_code == CMD_CLEAR);
    s_nxt.en_prev = en;
    // enable pin toggle: count the low time, act on the rising edge
    if (!en) begin
      s_nxt.en_low_cnt = s_r.en_low_cnt + {3'b000, s_r.en_low_cnt != 4'hf}; // saturates
    end else begin
      s_nxt.en_low_cnt = 4'h0;
      if (!s_r.en_prev && s_r.en_low_cnt >= EN_LOW_MIN) begin
        clr = 1'b1;
        s_nxt.latched = 1'b0; // the pin restart, unlike the command
      end
    end
    // clear every status bit first, so any set later in this pass wins; latch-off is kept
    if (clr) begin
      s_nxt.st_byte = 8'h00;
      s_nxt.st_comm = 8'h00;
      s_nxt.ls_on = 1'b0;
    end
    // four-phase handshake: drop the answer once the request drops
    s_nxt.rsp_valid = s_r.rsp_valid && link.cmd_valid;
    if (take) begin
      s_nxt.rsp_valid = 1'b1;
      s_nxt.rsp_nack = 1'b0;
      s_nxt.rsp_data = 16'h0000;
      if (!link.cmd_write) begin
        // reads ignore the lock entirely
        if (link.cmd_code == CMD_WLOCK) begin
          s_nxt.rsp_data = {8'h00, s_r.wlock};
        end else if (link.cmd_code == CMD_OPERATION) begin
          s_nxt.rsp_data = {8'h00, s_r.oper};
        end else if (link.cmd_code == CMD_ON_OFF) begin
          s_nxt.rsp_data = {8'h00, s_r.on_off};
        end else if (link.cmd_code == CMD_VOUT) begin
          s_nxt.rsp_data = s_r.vout;
        end else if (link.cmd_code == CMD_VENDOR_F0) begin
          s_nxt.rsp_data = {8'h00, s_r.vendor};
        end else if (link.cmd_code == CMD_STATUS_BYTE) begin
          s_nxt.rsp_data = {8'h00, s_r.st_byte};
        end else if (link.cmd_code == CMD_STATUS_COMM) begin
          s_nxt.rsp_data = {8'h00, s_r.st_comm};
        end else begin
          s_nxt.rsp_nack = 1'b1; // unsupported code
          s_nxt.st_byte[STB_COMM] = 1'b1;
          s_nxt.st_comm[STC_BAD_CMD] = 1'b1;
        end
      end else if (link.cmd_code == CMD_CLEAR) begin
        s_nxt.rsp_nack = 1'b0; // status already cleared above
      end else if (link.cmd_code == CMD_STORE || link.cmd_code == CMD_RESTORE) begin
        // store and restore both land here: one shared engine
        s_nxt.rsp_valid = 1'b0; // answer withheld until done
        s_nxt.busy = 1'b1;
        s_nxt.busy_store = (link.cmd_code == CMD_STORE);
        s_nxt.busy_cnt = 24'h000000;
      end else if (!lock_allows(s_r.wlock, link.cmd_code)) begin
        s_nxt.rsp_nack = 1'b0; // dropped quietly, contents kept
      end else if (link.cmd_code == CMD_WLOCK) begin
        s_nxt.wlock = link.cmd_data[7:0];
        if (!lock_valid(link.cmd_data[7:0])) begin
          s_nxt.st_byte[STB_COMM] = 1'b1;
          s_nxt.st_comm[STC_BAD_DATA] = 1'b1;
        end
      end else if (link.cmd_code == CMD_OPERATION) begin
        s_nxt.oper = link.cmd_data[7:0];
      end else if (link.cmd_code == CMD_ON_OFF) begin
        s_nxt.on_off = link.cmd_data[7:0];
      end else if (link.cmd_code == CMD_VOUT) begin
        s_nxt.vout = link.cmd_data;
      end else if (link.cmd_code == CMD_VENDOR_F0) begin
        s_nxt.vendor = link.cmd_data[7:0];
      end else begin
        s_nxt.rsp_nack = 1'b1;
        s_nxt.st_byte[STB_COMM] = 1'b1;
        s_nxt.st_comm[STC_BAD_CMD] = 1'b1;
      end
    end
    // nonvolatile engine: bus stays silent for the whole span
    if (s_r.busy) begin
      s_nxt.busy_cnt = s_r.busy_cnt + 24'h000001;
      if (s_r.busy_cnt == BUSY_LAST) begin
        s_nxt.busy = 1'b0;
        s_nxt.rsp_valid = 1'b1;
        s_nxt.rsp_nack = 1'b0;
        s_nxt.rsp_data = 16'h0000;
        if (s_r.busy_store && s_r.sy2[0]) begin
          s_nxt.rsp_nack = 1'b1;
          s_nxt.st_byte[STB_COMM] = 1'b1;
          s_nxt.st_comm[STC_MEMORY] = 1'b1;
        end else if (s_r.busy_store) begin
          s_nxt.nvm = {{8'h00, s_r.vendor}, s_r.vout, {8'h00, s_r.on_off},
                       {8'h00, s_r.oper}, {8'h00, s_r.wlock}};
        end else begin
          // each slot reloads only if the current lock lets it through
          if (lock_allows(s_r.wlock, CMD_OPERATION)) begin
            s_nxt.oper = s_r.nvm[1][7:0];
          end
          if (lock_allows(s_r.wlock, CMD_ON_OFF)) begin
            s_nxt.on_off = s_r.nvm[2][7:0];
          end
          if (lock_allows(s_r.wlock, CMD_VOUT)) begin
            s_nxt.vout = s_r.nvm[3];
          end
          if (lock_allows(s_r.wlock, CMD_VENDOR_F0)) begin
            s_nxt.vendor = s_r.nvm[4][7:0];
          end
          s_nxt.wlock = s_r.nvm[0][7:0]; // the lock itself is never locked
        end
      end
    end
    // feedback release only when the select bit asks for it
    if (s_r.vendor[OVERVOLT_RELEASE_SELECT] && fb_low) begin
      s_nxt.ls_on = 1'b0;
    end
    // live faults set after the clear so they are never lost
    if (ov) begin
      s_nxt.st_byte[STB_OVERVOLT] = 1'b1;
      s_nxt.ls_on = 1'b1;
      s_nxt.latched = 1'b1;
    end
    if (oth) begin
      s_nxt.st_byte[STB_OTHER] = 1'b1;
    end
    // alert follows the status contents, so it falls with the clear
    s_nxt.alert = (|s_nxt.st_byte) || (|s_nxt.st_comm);
  end
  // ************************************************************
  // registers
  // ************************************************************
  // one register bank for the whole block, link clock domain
  always_ff @(posedge link.link_clk) begin
    if (reset) begin
      s_r <= '{sy1: 5'h10, sy2: 5'h10, en_prev: 1'b1, en_low_cnt: 4'h0,
               rsp_valid: 1'b0, rsp_nack: 1'b0, rsp_data: 16'h0000, alert: 1'b0,
               wlock: WLOCK_RST, oper: OPERATION_RST, on_off: ON_OFF_RST,
               vout: VOUT_RST, vendor: VENDOR_F0_RST, st_byte: 8'h00,
               st_comm: 8'h00, ls_on: 1'b0, latched: 1'b0, busy: 1'b0,
               busy_store: 1'b0, busy_cnt: 24'h000000, nvm: {{8'h00, VENDOR_F0_RST}, VOUT_RST,
                     {8'h00, ON_OFF_RST}, {8'h00, OPERATION_RST}, {8'h00, WLOCK_RST}}};
    end else begin
      s_r <= s_nxt;
    end
  end
  // ************************************************************
  // outputs
  // ************************************************************
  assign link.rsp_valid = s_r.rsp_valid;
  assign link.rsp_nack = s_r.rsp_nack;
  assign link.rsp_data = s_r.rsp_data;
  assign link.alert = s_r.alert;
  assign low_side_switch_on = s_r.ls_on;
  assign latched_off = s_r.latched;
  assign faults_ignored = s_r.busy && s_r.busy_store;
  assign switching_halted = s_r.busy && !s_r.busy_store; // restore stops switching
  assign operation_out = s_r.oper;
  assign on_off_out = s_r.on_off;
  assign vout_out = s_r.vout;
endmodule // pfcn_dev_end
`default_nettype wire

// *** verilog/pfcn_host_end.sv ***
// bus host end: makes link_clk and runs one command at a time
// assumes a user that waits req_ready; answers cross back through two flops
`timescale 1ns/1ps
`default_nettype none
module pfcn_host_end
  import pfcn_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  pfcn_link_if.host link,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_code,
  input wire logic [15:0] req_data,
  output logic req_ready,
  output logic resp_valid,
  output logic resp_nack,
  output logic [15:0] resp_data,
  output logic alert_seen
);
  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00, // waiting for a user request
    HS_ARM = 2'b01, // request taken, raise at next low phase
    HS_WAIT = 2'b10, // request up, wait for the answer
    HS_DROP = 2'b11 // request down, wait for the answer to drop
  } pfcn_hstate_type;
  typedef struct packed {
    pfcn_hstate_type st;
    logic [1:0] div; // half-period counter
    logic lclk; // link clock
    logic cmd_valid;
    logic cmd_write;
    logic [7:0] cmd_code;
    logic [15:0] cmd_data;
    logic [1:0] rsp_s; // answer sync: [0] first stage, [1] second
    logic [1:0] alr_s; // alert sync
    logic ready;
    logic rvalid;
    logic rnack;
    logic [15:0] rdata;
  } pfcn_host_type;
  pfcn_host_type h_r, h_nxt;
  localparam logic [1:0] HALF_LAST = 2'(LINK_HALF_CYC - 1); // last count of a half period
  // ************************************************************
  // next state
  // ************************************************************
  // cmd_valid only moves as the link clock falls; code, data and write load in idle while cmd_valid is low
  always_comb begin
    logic fall;
    h_nxt = h_r;
    h_nxt.rsp_s = {h_r.rsp_s[0], link.rsp_valid};
    h_nxt.alr_s = {h_r.alr_s[0], link.alert};
    h_nxt.rvalid = 1'b0;
    fall = 1'b0;
    // divider: free running link clock
    if (h_r.div == HALF_LAST) begin
      h_nxt.div = 2'b00;
      h_nxt.lclk = !h_r.lclk;
      fall = h_r.lclk;
    end else begin
      h_nxt.div = h_r.div + 2'b01;
    end
    case (h_r.st)
      HS_IDLE: begin
        if (req_valid) begin
          h_nxt.cmd_write = req_write;
          h_nxt.cmd_code = req_code;
          h_nxt.cmd_data = req_data;
          h_nxt.ready = 1'b0;
          h_nxt.st = HS_ARM;
        end
      end
      HS_ARM: begin
        if (fall) begin
          h_nxt.cmd_valid = 1'b1;
          h_nxt.st = HS_WAIT;
        end
      end
      HS_WAIT: begin
        // no timeout: store and restore leave the far end silent a long while
        if (h_r.rsp_s[1] && fall) begin
          h_nxt.cmd_valid = 1'b0;
          h_nxt.rvalid = 1'b1;
          h_nxt.rnack = link.rsp_nack; // word held steady while the answer stands
          h_nxt.rdata = link.rsp_data;
          h_nxt.st = HS_DROP;
        end
      end
      HS_DROP: begin
        if (!h_r.rsp_s[1]) begin
          h_nxt.ready = 1'b1;
          h_nxt.st = HS_IDLE;
        end
      end
      default: begin
        h_nxt.st = HS_IDLE;
      end
    endcase
  end
  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      h_r <= '{st: HS_IDLE, div: 2'b00, lclk: 1'b0, cmd_valid: 1'b0, cmd_write: 1'b0,
               cmd_code: 8'h00, cmd_data: 16'h0000, rsp_s: 2'b00, alr_s: 2'b00,
               ready: 1'b1, rvalid: 1'b0, rnack: 1'b0, rdata: 16'h0000};
    end else begin
      h_r <= h_nxt;
    end
  end
  // ************************************************************
  // outputs
  // ************************************************************
  assign link.link_clk = h_r.lclk;
  assign link.cmd_valid = h_r.cmd_valid;
  assign link.cmd_write = h_r.cmd_write;
  assign link.cmd_code = h_r.cmd_code;
  assign link.cmd_data = h_r.cmd_data;
  assign req_ready = h_r.ready;
  assign resp_valid = h_r.rvalid;
  assign resp_nack = h_r.rnack;
  assign resp_data = h_r.rdata;
  assign alert_seen = h_r.alr_s[1];
endmodule // pfcn_host_end
`default_nettype wire

// *** verif/pfcn_link_props.sv ***
// link checker: timing and answer relations between the two ends
// assumes reset is the device end's reset, synchronous to link_clk
`timescale 1ns/1ps
`default_nettype none
module pfcn_link_props
  import pfcn_pkg::*;
(
  input wire logic link_clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic rsp_nack,
  input wire logic [15:0] rsp_data,
  input wire logic alert
);
  // ****************
  // helper terms
  // ****************
  localparam int BUSY_MAX = 80; // ceiling on the shortened busy span, with slack
  // store and restore make the device go quiet
  wire nvm = cmd_write && (cmd_code == CMD_STORE || cmd_code == CMD_RESTORE);
  wire rd_ok = !cmd_write && (cmd_code inside {CMD_OPERATION, CMD_ON_OFF, CMD_WLOCK, CMD_VOUT,
    CMD_STATUS_BYTE, CMD_STATUS_COMM, CMD_VENDOR_F0}); // readable codes
  wire wr_reg = cmd_write && (cmd_code inside {CMD_OPERATION, CMD_ON_OFF, CMD_VOUT, CMD_VENDOR_F0});
  wire bad_lock = cmd_write && cmd_code == CMD_WLOCK && $countones(cmd_data[7:5]) > 1;
  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (reset);
  // ****************
  // assertions
  // ****************
  AST_PROMPT: assert property ($rose(cmd_valid) && !nvm |=> rsp_valid)
    else $error("link answer late");
  AST_NVM_QUIET: assert property ($rose(cmd_valid) && nvm |=> !rsp_valid [*8])
    else $error("answer during busy span");
  AST_NVM_DONE: assert property ($rose(cmd_valid) && nvm |-> ##[9:BUSY_MAX] rsp_valid)
    else $error("busy span never ended");
  AST_HOLD: assert property (rsp_valid && cmd_valid |=> rsp_valid)
    else $error("answer dropped early");
  AST_DROP: assert property (rsp_valid && !cmd_valid |=> !rsp_valid)
    else $error("answer held too long");
  AST_READ_OK: assert property ($rose(rsp_valid) && rd_ok |-> !rsp_nack)
    else $error("read refused");
  AST_WRITE_ACK: assert property ($rose(rsp_valid) && wr_reg |-> !rsp_nack)
    else $error("register write refused");
  AST_LOCK_BAD: assert property ($rose(rsp_valid) && bad_lock |-> ##[0:2] alert)
    else $error("bad lock value raised no alert");
  AST_READ_UPPER: assert property ($rose(rsp_valid) && rd_ok && cmd_code != CMD_VOUT
    |-> rsp_data[15:8] == 8'h00)
    else $error("byte register read upper bits");
endmodule // pfcn_link_props
`default_nettype wire

// *** verif/pfcn_tb_top.sv ***
// bench: host end and device end joined by the link, driven from the host user port
// assumes the host end makes link_clk; expectations come from the lock table below
`timescale 1ns/1ps
`default_nettype none
module pfcn_tb_top;
  import pfcn_pkg::*;
  localparam int BUSY = 20; // shortened busy span keeps store/restore quick
  localparam logic [7:0] LOCKS [5] = '{8'h80, 8'h40, 8'h20, 8'he0, 8'h00};
  localparam logic [7:0] CODES [4] = '{CMD_OPERATION, CMD_ON_OFF, CMD_VOUT, CMD_VENDOR_F0};
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic dev_reset = 1'b1; // held longer so link_clk runs during device reset
  logic enable_pin_input = 1'b1;
  logic overvolt_fault_in = 1'b0;
  logic other_fault_in = 1'b0;
  logic feedback_below_in = 1'b0;
  logic nvm_fail_in = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [7:0] req_code = 8'h00;
  logic [15:0] req_data = 16'h0000;
  logic req_ready, resp_valid, resp_nack, alert_seen, low_side_switch_on, latched_off;
  logic faults_ignored, switching_halted;
  logic seen_fi = 1'b0;
  logic seen_sh = 1'b0;
  logic [7:0] operation_out, on_off_out;
  logic [15:0] vout_out, resp_data;
  logic [15:0] mdl [4] = '{16'h0000, 16'h0016, 16'h0000, 16'h0000}; // expected contents
  int err_count = 0;
  int n_tests = 0;
  always #5 clock = ~clock;
  pfcn_link_if link ();
  pfcn_host_end pfcn_host_end_inst (.clock(clock), .reset(reset), .link(link),
    .req_valid(req_valid), .req_write(req_write), .req_code(req_code), .req_data(req_data),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_nack(resp_nack),
    .resp_data(resp_data), .alert_seen(alert_seen));
  pfcn_dev_end #(.BUSY_CYC(BUSY)) pfcn_dev_end_inst (.reset(dev_reset), .link(link),
    .enable_pin_input(enable_pin_input), .overvolt_fault_in(overvolt_fault_in),
    .other_fault_in(other_fault_in), .feedback_below_in(feedback_below_in),
    .nvm_fail_in(nvm_fail_in), .low_side_switch_on(low_side_switch_on),
    .latched_off(latched_off), .faults_ignored(faults_ignored),
    .switching_halted(switching_halted), .operation_out(operation_out),
    .on_off_out(on_off_out), .vout_out(vout_out));
  pfcn_link_props pfcn_link_props_inst (.link_clk(link.link_clk), .reset(dev_reset),
    .cmd_valid(link.cmd_valid), .cmd_write(link.cmd_write), .cmd_code(link.cmd_code),
    .cmd_data(link.cmd_data), .rsp_valid(link.rsp_valid), .rsp_nack(link.rsp_nack),
    .rsp_data(link.rsp_data), .alert(link.alert));
  // ****************
  // helpers
  // ****************
  // remember that the busy indications were ever shown
  always @(posedge clock) begin
    if (faults_ignored === 1'b1) seen_fi <= 1'b1;
    if (switching_halted === 1'b1) seen_sh <= 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one request on the user port; answer left in resp_nack/resp_data
  task automatic req(input logic w, input logic [7:0] c, input logic [15:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 9999) begin
      tick(1);
      n++;
    end
    @(posedge clock);
    req_write <= w;
    req_code <= c;
    req_data <= d;
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (resp_valid !== 1'b1 && n < 9999);
    if (resp_valid !== 1'b1) err_count++; // no answer counts as a mismatch
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    req(1'b0, c, 16'h0000);
    chk($sformatf("read %h", c), {1'b0, e}, {resp_nack, resp_data});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic bit ok(input logic [7:0] l, input int i);
    return l == 8'h80 ? 1'b0 : l == 8'h40 ? i == 0 : l == 8'h20 ? i < 3 : 1'b1;
  endfunction
  // ****************
  // tests
  // ****************
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    repeat (40) @(posedge clock);
    dev_reset <= 1'b0;
    tick(10);
    foreach (LOCKS[k]) begin
      req(1'b1, CMD_WLOCK, {8'h00, LOCKS[k]});
      for (int i = 0; i < 4; i++) begin
        req(1'b1, CODES[i], 16'(8 * k + i + 1));
        if (ok(LOCKS[k], i)) mdl[i] = 16'(8 * k + i + 1);
      end
      for (int i = 0; i < 4; i++) rd(CODES[i], mdl[i]);
      rd(CMD_WLOCK, {8'h00, LOCKS[k]});
    end
    rd(CMD_STATUS_BYTE, 16'h0002);
    rd(CMD_STATUS_COMM, 16'h0040);
    chk("alert", 17'(1), 17'(alert_seen));
    req(1'b1, CMD_CLEAR, 16'h0000);
    tick(10);
    rd(CMD_STATUS_BYTE, 16'h0000);
    rd(CMD_STATUS_COMM, 16'h0000);
    chk("alert", 17'(0), 17'(alert_seen));
    $display("test lock done");
    @(posedge clock);
    overvolt_fault_in <= 1'b1;
    tick(30);
    overvolt_fault_in <= 1'b0;
    feedback_below_in <= 1'b1;
    tick(30);
    chk("low side", 17'(1), 17'(low_side_switch_on));
    rd(CMD_STATUS_BYTE, 16'h0020);
    req(1'b1, CMD_CLEAR, 16'h0000);
    tick(30);
    chk("low side", 17'(0), 17'(low_side_switch_on));
    chk("latched", 17'(1), 17'(latched_off));
    chk("alert", 17'(0), 17'(alert_seen));
    req(1'b1, CMD_VENDOR_F0, 16'h0001);
    feedback_below_in <= 1'b0;
    overvolt_fault_in <= 1'b1;
    tick(30);
    overvolt_fault_in <= 1'b0;
    chk("low side", 17'(1), 17'(low_side_switch_on));
    feedback_below_in <= 1'b1;
    tick(30);
    chk("low side", 17'(0), 17'(low_side_switch_on));
    enable_pin_input <= 1'b0;
    tick(80);
    enable_pin_input <= 1'b1;
    tick(30);
    chk("latched", 17'(0), 17'(latched_off));
    rd(CMD_STATUS_BYTE, 16'h0000);
    other_fault_in <= 1'b1;
    tick(30);
    req(1'b1, CMD_CLEAR, 16'h0000);
    tick(30);
    rd(CMD_STATUS_BYTE, 16'h0001);
    chk("alert", 17'(1), 17'(alert_seen));
    other_fault_in <= 1'b0;
    req(1'b1, CMD_CLEAR, 16'h0000);
    $display("test fault done");
    req(1'b1, CMD_OPERATION, 16'h0033);
    req(1'b1, CMD_VOUT, 16'h0123);
    req(1'b1, CMD_STORE, 16'h0000);
    chk("store", 17'h00001, {resp_nack, 15'h0000, seen_fi});
    req(1'b1, CMD_VOUT, 16'h0456);
    req(1'b1, CMD_OPERATION, 16'h0044);
    req(1'b1, CMD_WLOCK, 16'h0040);
    req(1'b1, CMD_RESTORE, 16'h0000);
    chk("restore", 17'h00001, {resp_nack, 15'h0000, seen_sh});
    rd(CMD_OPERATION, 16'h0033);
    rd(CMD_VOUT, 16'h0456);
    rd(CMD_WLOCK, 16'h0000);
    chk("operation", 17'h00033, {9'h000, operation_out});
    chk("on_off", 17'h00022, {9'h000, on_off_out});
    chk("vout", 17'h00456, {1'b0, vout_out});
    nvm_fail_in <= 1'b1;
    req(1'b1, CMD_STORE, 16'h0000);
    chk("store nack", 17'(1), 17'(resp_nack));
    nvm_fail_in <= 1'b0;
    rd(CMD_STATUS_BYTE, 16'h0002);
    rd(CMD_STATUS_COMM, 16'h0010);
    $display("test store done");
    give_verdict();
  end
  // watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (50000) @(posedge clock);
    err_count++;
    give_verdict();
  end
endmodule // pfcn_tb_top
`default_nettype wire
